// ==== hw/ucs_pkg.sv ====
// package: constants and types shared by both ends of the control endpoint link
package ucs_pkg;
  // token and handshake codes carried on the link
  typedef enum logic [2:0] {
    UCS_TOK_NONE,
    UCS_TOK_SETUP,
    UCS_TOK_IN,
    UCS_TOK_OUT
  } ucs_tok_t;
  typedef enum logic [1:0] {
    UCS_HS_NONE,
    UCS_HS_ACK,
    UCS_HS_NAK,
    UCS_HS_DATA
  } ucs_hs_t;
  // clock rate and the token crc-bit window
  localparam int UCS_CLK_HZ = 10000000;
  localparam int UCS_CRC_BIT_NS = 83;
  localparam int UCS_CRC_BIT_CYC_RAW = (UCS_CRC_BIT_NS * (UCS_CLK_HZ / 1000000)) / 1000;
  localparam int UCS_CRC_BIT_CYC = (UCS_CRC_BIT_CYC_RAW < 1) ? 1 : UCS_CRC_BIT_CYC_RAW;
  // reset values
  localparam logic UCS_FLAG_RST = 1'b0;
  localparam logic UCS_GATE_RST = 1'b0;
  localparam logic [1:0] UCS_PWR_RST = 2'h0;
  // data byte count width
  localparam int UCS_LEN_W = 4;
endpackage

// ==== hw/ucs_link_if.sv ====
// interface: token, handshake and data link between host and device ends
`timescale 1ns/1ns
interface ucs_link_if;
  import ucs_pkg::*;
  ucs_tok_t tok; // token from host, one-cycle pulse
  logic tok_crc2; // host is in the second crc bit of the token
  ucs_hs_t hs; // device answer, one cycle per token, held at data through a stream
  logic [7:0] data; // data byte with hs data
  logic vbus; // bus power present
  modport host (output tok, output tok_crc2, output vbus, input hs, input data);
  modport dev (input tok, input tok_crc2, input vbus, output hs, output data);
endinterface

// ==== hw/ucs_dev.sv ====
// device end: control endpoint 0 setup handling, enable and power control
// Summary of operation
// - setup token sets flag and raises interrupt
// - in tokens naked while flag set
// - software clears flag after preparing data
// - flag clear in crc window is harmless
// - enable clear resets module, leaves transmit
// - gates clear blocks flag-clear event
// - use gate sequence only when needed
// - status bit reports valid bus power
// - power control all-zero clears detect failure
`timescale 1ns/1ns
module ucs_dev
  import ucs_pkg::*;
#(
  parameter int LEN_W = ucs_pkg::UCS_LEN_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // link
  ucs_link_if.dev link,
  // software controls
  input wire logic module_enable_bit_in,
  input wire logic in_ep0_gate_in,
  input wire logic out_ep0_gate_in,
  input wire logic flag_clear_in,
  input wire logic [LEN_W-1:0] in_len_in,
  input wire logic [1:0] power_control_in,
  // software status
  output logic setup_received_flag_out,
  output logic usb_irq_out,
  output logic vbus_valid_status_out,
  output logic transmitting_out
);
  import ucs_pkg::*;

  // endpoint 0 state
  logic flag_q; // setup received, waits for software
  logic irq_q; // interrupt level toward software
  logic tx_q; // data stream in progress
  logic [LEN_W-1:0] tx_cnt_q; // bytes left to send
  logic [7:0] next_byte_q; // value of the next streamed byte
  logic [7:0] data_q; // data byte on the link
  ucs_hs_t hs_q; // handshake on the link

  // bus power state
  logic vbus_q; // bus power reported valid
  logic det_fail_q; // failed detect state, only ever cleared

  // decoded link and control terms
  logic tok_setup; // setup token this cycle
  logic tok_in; // in token this cycle
  logic tok_out; // out token this cycle
  logic gates_on; // both endpoint gates set
  logic engine_idle; // disabled or gated: no handshakes
  logic clr_ok; // flag clear that takes effect
  logic start_tx; // in token that opens a data stream
  logic zero_len; // no data prepared for the in stage
  logic pwr_zero; // power control all zero

  // token decode; one token at most per cycle
  assign tok_setup = (link.tok == UCS_TOK_SETUP);
  assign tok_in = (link.tok == UCS_TOK_IN);
  assign tok_out = (link.tok == UCS_TOK_OUT);

  // both configurations must be active for the endpoint to answer
  assign gates_on = in_ep0_gate_in & out_ep0_gate_in;
  assign engine_idle = !module_enable_bit_in | !gates_on;

  // clear only counts while gated on; a clear in the crc window of an
  // in token is still safe, since a stream only opens on a whole in token
  // sampled with the flag already low, and its length is bounded
  assign clr_ok = flag_clear_in & gates_on;

  // a stream needs the flag low, data prepared and no stream running
  assign zero_len = (in_len_in == '0);
  assign start_tx = tok_in & !flag_q & !zero_len & !tx_q;

  // all-zero power control is the recovery write
  assign pwr_zero = (power_control_in == UCS_PWR_RST);

  // setup flag: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      flag_q <= UCS_FLAG_RST;
    end else if (!module_enable_bit_in) begin
      // module reset through the enable bit
      flag_q <= UCS_FLAG_RST;
    end else if (tok_setup) begin
      // every setup raises the flag, even while gated
      flag_q <= 1'b1;
    end else if (clr_ok) begin
      // software has prepared the in data
      flag_q <= 1'b0;
    end
  end

  // interrupt rises with the flag and follows it
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      irq_q <= 1'b0;
    end else begin
      // held low while the module is off
      irq_q <= module_enable_bit_in & (flag_q | tok_setup);
    end
  end

  // stream length: a bounded count, so no clear timing can make it endless
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      tx_q <= 1'b0;
      tx_cnt_q <= '0;
    end else if (engine_idle || tok_setup) begin
      // disabled, gated or a new setup: leave any stream
      tx_q <= 1'b0;
      tx_cnt_q <= '0;
    end else if (tx_q) begin
      // one byte per cycle, stop after the last
      tx_q <= (tx_cnt_q > LEN_W'(1));
      tx_cnt_q <= tx_cnt_q - LEN_W'(1);
    end else if (start_tx) begin
      // load the prepared length
      tx_q <= 1'b1;
      tx_cnt_q <= in_len_in;
    end
  end

  // streamed bytes count up from zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      data_q <= 8'h00;
      next_byte_q <= 8'h00;
    end else if (engine_idle || tok_setup || start_tx) begin
      // idle or a fresh stream: restart the byte count
      data_q <= 8'h00;
      next_byte_q <= 8'h00;
    end else if (tx_q) begin
      // put out the next byte
      data_q <= next_byte_q;
      next_byte_q <= next_byte_q + 8'h01;
    end
  end

  // handshake answer, one cycle after the token
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      hs_q <= UCS_HS_NONE;
    end else if (engine_idle) begin
      // disabled or gated: no answer at all
      hs_q <= UCS_HS_NONE;
    end else if (tok_setup) begin
      // setup is always taken, even over a stream
      hs_q <= UCS_HS_ACK;
    end else if (tx_q) begin
      // stream in progress, other tokens ignored
      hs_q <= UCS_HS_DATA;
    end else if (tok_in && flag_q) begin
      // setup still pending: hold the host off
      hs_q <= UCS_HS_NAK;
    end else if (tok_in && zero_len) begin
      // no data prepared: zero-length data stage
      hs_q <= UCS_HS_DATA;
    end else if (tok_out) begin
      // status or data out stage
      hs_q <= UCS_HS_ACK;
    end else begin
      // no token, or an in that opens a stream next cycle
      hs_q <= UCS_HS_NONE;
    end
  end

  // failed detect state: only ever cleared, by the all-zero power
  // control write, never set from inside
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      det_fail_q <= 1'b0;
    end else if (pwr_zero) begin
      // recovery write clears a failed detect
      det_fail_q <= 1'b0;
    end
  end

  // valid bus power, masked while regulators are off or detect failed
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // power-on idle
      vbus_q <= 1'b0;
    end else begin
      vbus_q <= link.vbus & !pwr_zero & !det_fail_q;
    end
  end

  // link drive
  assign link.hs = hs_q;
  assign link.data = data_q;

  // status outputs, each straight from its flip-flop
  assign setup_received_flag_out = flag_q;
  assign usb_irq_out = irq_q;
  assign vbus_valid_status_out = vbus_q;
  assign transmitting_out = tx_q;
endmodule

// ==== hw/ucs_host.sv ====
// host end: issues tokens on the link and collects answers
`timescale 1ns/1ns
module ucs_host
  import ucs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // link
  ucs_link_if.host link,
  // user requests
  input wire logic send_setup_in,
  input wire logic send_in_in,
  input wire logic send_out_in,
  input wire logic vbus_on_in,
  // user results
  output ucs_pkg::ucs_hs_t last_hs_out,
  output logic [7:0] last_data_out,
  output logic busy_out
);
  import ucs_pkg::*;
  ucs_tok_t tok_q; // token pulse
  logic crc2_q; // crc window marker
  logic vbus_q; // bus power drive
  ucs_hs_t hs_q; // captured answer
  logic [7:0] d_q; // captured data
  logic busy_q; // token on the link this cycle
  // token issue, setup has priority
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tok_q <= UCS_TOK_NONE;
      crc2_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      crc2_q <= 1'b0;
      busy_q <= send_setup_in | send_in_in | send_out_in;
      if (send_setup_in) begin
        tok_q <= UCS_TOK_SETUP;
      end else if (send_in_in) begin
        tok_q <= UCS_TOK_IN;
        crc2_q <= 1'b1;
      end else if (send_out_in) begin
        tok_q <= UCS_TOK_OUT;
      end else begin
        tok_q <= UCS_TOK_NONE;
      end
    end
  end
  // bus power and answer capture
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vbus_q <= 1'b0;
      hs_q <= UCS_HS_NONE;
      d_q <= 8'h00;
    end else begin
      vbus_q <= vbus_on_in;
      if (link.hs != UCS_HS_NONE) begin
        hs_q <= link.hs;
        d_q <= link.data;
      end
    end
  end
  assign link.tok = tok_q;
  assign link.tok_crc2 = crc2_q;
  assign link.vbus = vbus_q;
  assign last_hs_out = hs_q;
  assign last_data_out = d_q;
  assign busy_out = busy_q;
endmodule

// ==== tb/ucs_props.sv ====
// checker: link and control relations of the endpoint block
`timescale 1ns/1ns
module ucs_props
  import ucs_pkg::*;
(
  // clock, reset, link
  input logic sys_clk_in,
  input logic rst_b_in,
  input ucs_pkg::ucs_tok_t tok,
  input logic tok_crc2,
  input ucs_pkg::ucs_hs_t hs,
  input logic vbus,
  // device controls and status
  input logic module_enable_bit_in,
  input logic in_ep0_gate_in,
  input logic out_ep0_gate_in,
  input logic flag_clear_in,
  input logic [1:0] power_control_in,
  input logic setup_received_flag_out,
  input logic usb_irq_out,
  input logic vbus_valid_status_out
);
  import ucs_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // enabled with both gates open
  wire logic ok = module_enable_bit_in & in_ep0_gate_in & out_ep0_gate_in;
  wire logic fl = setup_received_flag_out;
  wire logic pw = |power_control_in;
  setup_flag_a: assert property (ok && tok == UCS_TOK_SETUP |=> fl && hs == UCS_HS_ACK)
    else $error("setup not taken");
  irq_follow_a: assert property ($rose(fl) |-> ##[0:1] usb_irq_out)
    else $error("no irq on flag");
  in_nak_a: assert property (ok && fl && tok == UCS_TOK_IN |=> hs == UCS_HS_NAK)
    else $error("in not naked");
  crc_clear_a: assert property (ok && fl && flag_clear_in && tok_crc2 |=> hs == UCS_HS_NAK && !fl)
    else $error("clear at in token");
  en_reset_a: assert property (!module_enable_bit_in |=> !fl && !usb_irq_out && hs == UCS_HS_NONE)
    else $error("enable clear kept state");
  gate_block_a: assert property (module_enable_bit_in && fl && !in_ep0_gate_in |=> fl)
    else $error("clear not gated");
  vbus_ok_a: assert property (vbus && pw ##1 vbus && pw |-> vbus_valid_status_out)
    else $error("vbus not reported");
  pwr_clear_a: assert property (!pw ##1 !pw |-> !vbus_valid_status_out)
    else $error("power clear ignored");
endmodule

// ==== tb/tb_top.sv ====
// testbench: both ends joined on the link, checked against expected values (stream bytes built from a random length) and the ucs_props assertions
`timescale 1ns/1ns
module tb_top;
  import ucs_pkg::*;
  logic sys_clk_in = 0, rst_b_in = 0, en = 0, g = 0, clr = 0, s_set = 0, s_in = 0, s_out = 0, vb = 1;
  logic [3:0] len = 0;
  logic [1:0] pwr = 2'h3;
  logic flag, irq, vst, tx;
  ucs_hs_t h_hs; // host's last answer
  logic [7:0] h_d; // host's last data byte
  logic h_busy; // host token in flight
  logic [7:0] q[$]; // expected data bytes
  int error_cnt = 0, total_checks = 0, cyc = 0, n;
  ucs_link_if link();
  ucs_dev i_ucs_dev (.sys_clk_in, .rst_b_in, .link, .module_enable_bit_in(en), .in_ep0_gate_in(g),
    .out_ep0_gate_in(g), .flag_clear_in(clr), .in_len_in(len), .power_control_in(pwr),
    .setup_received_flag_out(flag), .usb_irq_out(irq), .vbus_valid_status_out(vst), .transmitting_out(tx));
  ucs_host i_ucs_host (.sys_clk_in, .rst_b_in, .link, .send_setup_in(s_set), .send_in_in(s_in),
    .send_out_in(s_out), .vbus_on_in(vb), .last_hs_out(h_hs), .last_data_out(h_d), .busy_out(h_busy));
  ucs_props u_props (.sys_clk_in, .rst_b_in, .tok(link.tok), .tok_crc2(link.tok_crc2), .hs(link.hs),
    .vbus(link.vbus),
    .module_enable_bit_in(en), .in_ep0_gate_in(g), .out_ep0_gate_in(g), .flag_clear_in(clr),
    .power_control_in(pwr), .setup_received_flag_out(flag), .usb_irq_out(irq), .vbus_valid_status_out(vst));
  // clock and hang guard
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (++cyc > 3000) begin
    error_cnt++;
    close_out;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one token, optional clear in its cycle; returns at the answer cycle
  task automatic tok_go(int k, logic c);
    {s_set, s_in, s_out} = (k == 0) ? 3'b100 : (k == 1) ? 3'b010 : 3'b001;
    @(negedge sys_clk_in);
    chk("busy", h_busy, 1);
    {s_set, s_in, s_out} = 3'b000;
    clr = c;
    @(negedge sys_clk_in);
    if (c) clr = 0;
  endtask
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    n = $urandom(27);
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1; en = 1; g = 1;
    @(negedge sys_clk_in);
    for (int k = 2; k >= 0; k -= 2) begin // out, then setup
      tok_go(k, 0);
      chk("ack", link.hs, UCS_HS_ACK);
    end
    chk("flag", flag, 1);
    chk("irq", irq, 1);
    tok_go(1, 0);
    chk("nak", link.hs, UCS_HS_NAK);
    g = 0; clr = 1; // gated clear is lost
    @(negedge sys_clk_in);
    clr = 0; g = 1;
    @(negedge sys_clk_in);
    chk("gated", flag, 1);
    len = 4'($urandom_range(1, 6));
    tok_go(1, 1);
    chk("crc nak", link.hs, UCS_HS_NAK);
    chk("cleared", flag, 0);
    for (int i = 0; i < len; i++) q.push_back(8'(i));
    tok_go(1, 0);
    while (q.size() > 0) begin
      @(negedge sys_clk_in);
      chk("hs data", link.hs, UCS_HS_DATA);
      chk("byte", link.data, q.pop_front());
    end
    @(negedge sys_clk_in);
    chk("tx end", tx, 0);
    chk("host hs", h_hs, UCS_HS_DATA);
    chk("host byte", h_d, 8'(len - 4'h1));
    len = 4'h0;
    tok_go(1, 0);
    chk("zero len", link.hs, UCS_HS_DATA);
    tok_go(0, 0);
    en = 0;
    len = 4'hf;
    @(negedge sys_clk_in);
    chk("en flag", flag, 0);
    en = 1;
    tok_go(1, 0);
    repeat (3) @(negedge sys_clk_in);
    chk("tx on", tx, 1);
    en = 0;
    @(negedge sys_clk_in);
    chk("tx off", tx, 0);
    en = 1;
    tok_go(0, 0);
    chk("reinit", link.hs, UCS_HS_ACK);
    chk("vbus", vst, 1);
    pwr = 2'h0;
    repeat (2) @(negedge sys_clk_in);
    chk("pwr off", vst, 0);
    pwr = 2'h3;
    repeat (3) @(negedge sys_clk_in);
    chk("pwr on", vst, 1);
    close_out;
  end
endmodule
